// ### btc_pin_src.sv
// far-side model: source of pulses on the external count pin
module btc_pin_src (
    input  wire logic       clk_i,    // bench clock
    input  wire logic       rst_n_i,  // async reset, low
    input  wire logic       start_i,  // begin a burst
    input  wire logic [7:0] num_i,    // rising edges in the burst
    output logic            pin_o,    // count pin level
    output logic            busy_o    // burst in progress
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_r; // edges still to send
    logic [1:0] ph_r;   // phase: two cycles high, two low
    // ----------------------------------------
    // burst sequencer
    // ----------------------------------------
    // slow pulses so the two-flop synchronizer never misses an edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_r <= 8'h00;
            ph_r   <= 2'b00;
        end else if (start_i && left_r == 8'h00) begin
            left_r <= num_i;
            ph_r   <= 2'b00;
        end else if (left_r != 8'h00) begin
            ph_r <= ph_r + 2'b01;
            if (ph_r == 2'b11) left_r <= left_r - 8'h01;
        end
    end
    // pin rests low between bursts
    assign pin_o  = (left_r != 8'h00) && !ph_r[1];
    assign busy_o = (left_r != 8'h00);
endmodule : btc_pin_src

// ### btc_pkg.sv
// constants shared by the timer control block
package btc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned     ADDR_W          = 4;
    localparam int unsigned     DATA_W          = 16;
    localparam logic [3:0]      CTRL_OFS        = 4'h0;
    localparam logic [3:0]      COUNT_OFS       = 4'h4;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int unsigned     RUN_BIT         = 15;
    localparam int unsigned     IDLE_HALT_BIT   = 13;
    localparam int unsigned     GATE_BIT        = 6;
    localparam int unsigned     PRESC_HI_BIT    = 5;
    localparam int unsigned     PRESC_LO_BIT    = 4;
    localparam int unsigned     SYNC_BIT        = 2;
    localparam int unsigned     SRC_BIT         = 1;

    // writable bits; the rest read as zero
    localparam logic [15:0]     CTRL_WMASK      = 16'hA076;
    localparam logic [15:0]     CTRL_RESET      = 16'h0000;
    localparam logic [15:0]     COUNT_RESET     = 16'h0000;

    // ------------------------------------------------------------
    // prescaler terminal counts (divide minus one)
    // ------------------------------------------------------------
    localparam logic [7:0]      DIV1_M1         = 8'h00;
    localparam logic [7:0]      DIV8_M1         = 8'h07;
    localparam logic [7:0]      DIV64_M1        = 8'h3F;
    localparam logic [7:0]      DIV256_M1       = 8'hFF;
    localparam logic [7:0]      PRESC_RESET     = 8'h00;

    // prescale select codes
    typedef enum logic [1:0] {
        BTC_PS_1   = 2'b00,
        BTC_PS_8   = 2'b01,
        BTC_PS_64  = 2'b10,
        BTC_PS_256 = 2'b11
    } btc_presc_e;

endpackage : btc_pkg

// ### btc_timer.sv
// 16-bit general purpose timer with its control register
//
// Operation
// - idle-halt bit stops timer during idle mode
// - external source ignores the gate enable
// - gated mode counts only while gate active
// - prescale field divides by 1, 8, 64, 256
module btc_timer
    import btc_pkg::*;
#(
    parameter int unsigned CNT_W = 16          // counter width
) (
    input  wire logic              core_clk_i,   // peripheral clock
    input  wire logic              reset_n_i,    // async reset, low
    input  wire logic [ADDR_W-1:0] addr_i,       // register address
    input  wire logic [DATA_W-1:0] wr_data_i,    // write data
    input  wire logic              wr_strobe_i,  // write strobe
    input  wire logic              rd_strobe_i,  // read strobe
    input  wire logic              idle_mode_i,  // device in idle mode
    input  wire logic              gate_i,       // gate input, high
    input  wire logic              ext_pin_i,    // external count pin
    output logic [DATA_W-1:0]      rd_data_o,    // read data, next cycle
    output logic [CNT_W-1:0]       count_o,      // current count
    output logic                   tick_o        // count advanced pulse
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0]        ctrl_r;         // control register
    logic [15:0]        ctrl_nxt;       // its next value
    logic [DATA_W-1:0]  rd_data_r;      // read data holding
    logic [DATA_W-1:0]  rd_data_nxt;    // its next value
    logic               pin_s1_r;       // synchroniser stage one
    logic               pin_s2_r;       // synchroniser stage two
    logic               pin_s3_r;       // delayed synced level
    logic               pin_raw_r;      // delayed raw level
    logic               pin_s1_nxt;     // next stage one
    logic               pin_s2_nxt;     // next stage two
    logic               pin_s3_nxt;     // next delayed synced
    logic               pin_raw_nxt;    // next delayed raw
    logic [7:0]         presc_r;        // prescaler count
    logic [7:0]         presc_nxt;      // its next value
    logic [CNT_W-1:0]   count_r;        // timer count
    logic [CNT_W-1:0]   count_nxt;      // its next value
    logic               tick_r;         // advance pulse
    logic               tick_nxt;       // its next value

    // decoded control fields
    logic               run;            // count run control
    logic               idle_halt;      // idle halt select
    logic               gate_en;        // gate accumulate enable
    btc_presc_e         presc_sel;      // input prescale select
    logic               sync_sel;       // ext clock sync select
    logic               src_ext;        // clock source select
    logic [7:0]         div_m1;         // prescaler terminal
    logic               gate_eff;       // gate honoured
    logic               halted;         // stopped by idle mode
    logic               ext_edge;       // rising edge on pin
    logic               in_pulse;       // one input clock
    logic               wrap;           // prescaler rolls over
    logic               ctrl_wr;        // control write this cycle

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    assign run       = ctrl_r[RUN_BIT];
    assign idle_halt = ctrl_r[IDLE_HALT_BIT];
    assign gate_en   = ctrl_r[GATE_BIT];
    assign presc_sel = btc_presc_e'(ctrl_r[PRESC_HI_BIT:PRESC_LO_BIT]);
    assign sync_sel  = ctrl_r[SYNC_BIT];
    assign src_ext   = ctrl_r[SRC_BIT];
    assign ctrl_wr   = wr_strobe_i && (addr_i == CTRL_OFS);

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    // writes take effect at the strobe edge; unmapped reads give zero
    always_comb begin
        ctrl_nxt    = ctrl_r;
        rd_data_nxt = '0;
        if (ctrl_wr) begin
            ctrl_nxt = wr_data_i & CTRL_WMASK;
        end
        if (rd_strobe_i) begin
            unique case (addr_i)
                CTRL_OFS: begin
                    rd_data_nxt = ctrl_r;
                end
                COUNT_OFS: begin
                    rd_data_nxt = DATA_W'(count_r);
                end
                default: begin
                    rd_data_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r    <= CTRL_RESET;
            rd_data_r <= '0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // external pin capture
    // ------------------------------------------------------------
    // the synchronised path costs two cycles of latency but is safe
    // for a pin that moves freely; the raw path is quicker and
    // counts on the pin meeting setup to the clock
    always_comb begin
        pin_s1_nxt  = ext_pin_i;
        pin_s2_nxt  = pin_s1_r;
        pin_s3_nxt  = pin_s2_r;
        pin_raw_nxt = ext_pin_i;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_s1_r  <= 1'b0;
            pin_s2_r  <= 1'b0;
            pin_s3_r  <= 1'b0;
            pin_raw_r <= 1'b0;
        end else begin
            pin_s1_r  <= pin_s1_nxt;
            pin_s2_r  <= pin_s2_nxt;
            pin_s3_r  <= pin_s3_nxt;
            pin_raw_r <= pin_raw_nxt;
        end
    end

    // rising edge detect on the chosen path
    assign ext_edge = sync_sel ? (pin_s2_r && !pin_s3_r)
                               : (ext_pin_i && !pin_raw_r);

    // ------------------------------------------------------------
    // input clock selection and gating
    // ------------------------------------------------------------
    assign gate_eff = gate_en && !src_ext;
    assign halted   = idle_halt && idle_mode_i;

    // one input clock per peripheral cycle, per pin edge, or per
    // peripheral cycle while the gate is high
    always_comb begin
        if (src_ext) begin
            in_pulse = ext_edge;
        end else if (gate_eff) begin
            in_pulse = gate_i;
        end else begin
            in_pulse = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    always_comb begin
        unique case (presc_sel)
            BTC_PS_1: begin
                div_m1 = DIV1_M1;
            end
            BTC_PS_8: begin
                div_m1 = DIV8_M1;
            end
            BTC_PS_64: begin
                div_m1 = DIV64_M1;
            end
            BTC_PS_256: begin
                div_m1 = DIV256_M1;
            end
        endcase
    end

    assign wrap = run && !halted && in_pulse && (presc_r >= div_m1);

    // cleared while stopped and on every control write, so a new
    // ratio always starts from a clean phase
    always_comb begin
        presc_nxt = presc_r;
        if (!run || ctrl_wr) begin
            presc_nxt = PRESC_RESET;
        end else if (halted || !in_pulse) begin
            presc_nxt = presc_r;
        end else if (wrap) begin
            presc_nxt = PRESC_RESET;
        end else begin
            presc_nxt = presc_r + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            presc_r <= PRESC_RESET;
        end else begin
            presc_r <= presc_nxt;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // the count wraps at its full width; no period match here
    always_comb begin
        count_nxt = count_r;
        tick_nxt  = 1'b0;
        if (wrap) begin
            count_nxt = count_r + CNT_W'(1);
            tick_nxt  = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= CNT_W'(COUNT_RESET);
            tick_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r  <= tick_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data_o = rd_data_r;
    assign count_o   = count_r;
    assign tick_o    = tick_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // properties sample on the rising edge and sleep while in reset
    chk_idle_halt_hold: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (idle_halt && idle_mode_i) |=> $stable(count_r))
        else $error("count moved while halted in idle");

    chk_idle_runs_on: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (run && !idle_halt && idle_mode_i && !src_ext && !gate_en
         && presc_sel == BTC_PS_1)
        |=> count_r == $past(count_r) + CNT_W'(1))
        else $error("count stalled in idle without halt");

    chk_ext_no_gate: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (run && !halted && src_ext && ext_edge && !gate_i
         && presc_sel == BTC_PS_1)
        |=> count_r == $past(count_r) + CNT_W'(1))
        else $error("external edge lost to gate");

    chk_gate_block: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (!src_ext && gate_en && !gate_i) |=> $stable(count_r))
        else $error("gated timer advanced with gate low");

    chk_presc_bound: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (run && !ctrl_wr && presc_sel == BTC_PS_8 && !src_ext
         && !gate_en && !halted && presc_r == DIV1_M1)
        ##1 (run && !ctrl_wr && !halted) [*7]
        |-> ##1 count_r == $past(count_r, 8) + CNT_W'(1))
        else $error("divide by eight ratio wrong");

    chk_presc_range: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        presc_r <= div_m1)
        else $error("prescaler past its terminal");

    chk_run_freeze: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !run |=> $stable(count_r) && !tick_o)
        else $error("count moved while stopped");

    chk_read_latency: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (rd_strobe_i && addr_i == CTRL_OFS)
        |=> rd_data_o == $past(ctrl_r))
        else $error("control read data wrong");

    chk_gate_pass: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (run && !halted && !src_ext && gate_en && gate_i
         && presc_sel == BTC_PS_1)
        |=> count_r == $past(count_r) + CNT_W'(1))
        else $error("gated timer missed a gate-high cycle");

    // every advance shows as one tick beside a single step of count
    chk_tick_count: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        wrap |=> tick_o && count_r == $past(count_r) + CNT_W'(1))
        else $error("tick or count missed an advance");

    // read data must fall back to zero so a stale word is not mistaken
    // for a fresh answer
    chk_read_idle_zero: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !rd_strobe_i |=> rd_data_o == '0)
        else $error("read data held past its cycle");

endmodule : btc_timer

// ### testbench.sv
// self-checking bench for the timer control block
module testbench
    import btc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, reset_n, wr, rd, idle, gate, pin, start, busy;
    logic [3:0]  addr;
    logic [15:0] wdat, rdat, cnt, d;
    logic        tick;
    logic [7:0]  num;
    int fail_count, num_checks, cyc, ticks, t0, c1, k, n;
    btc_timer btc_timer_inst (.core_clk_i(core_clk), .reset_n_i(reset_n),
        .addr_i(addr), .wr_data_i(wdat), .wr_strobe_i(wr), .rd_strobe_i(rd),
        .idle_mode_i(idle), .gate_i(gate), .ext_pin_i(pin),
        .rd_data_o(rdat), .count_o(cnt), .tick_o(tick));
    btc_pin_src btc_pin_src_inst (.clk_i(core_clk), .rst_n_i(reset_n),
        .start_i(start), .num_i(num), .pin_o(pin), .busy_o(busy));
    // ----------------------------------------
    // clock, cycle and tick counters, hang guard
    // ----------------------------------------
    always #2.5 core_clk = ~core_clk;
    // counters move by non-blocking update so the main thread always
    // reads the values from before the current edge
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (tick === 1'b1) ticks <= ticks + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic step();
        @(posedge core_clk);
    endtask : step
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr_reg(logic [3:0] a, logic [15:0] v);
        wr <= 1'b1; addr <= a; wdat <= v;
        step();
        wr <= 1'b0;
        step();
    endtask : wr_reg
    // data stand only in the cycle after the strobe, then fall to zero
    task automatic rd_reg(logic [3:0] a, output logic [15:0] v);
        rd <= 1'b1;
        addr <= a;
        step();
        rd <= 1'b0;
        step();
        v = rdat;
        step();
        check("rd_idle", rdat, 16'h0000);
    endtask : rd_reg
    function automatic int div_of(int ps);
        return (ps == 0) ? 1 : (ps == 1) ? 8 : (ps == 2) ? 64 : 256;
    endfunction : div_of
    // ticks since t0, after letting the pipeline drain
    task automatic settle_ticks(string nm, int exp);
        repeat (6) step();
        check(nm, 16'(ticks - t0), 16'(exp));
    endtask : settle_ticks
    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        core_clk = 0; reset_n = 0; addr = 0; wdat = 0; wr = 0; rd = 0;
        idle = 0; gate = 0; start = 0; num = 0;
        void'($urandom(75));
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        step();
        rd_reg(CTRL_OFS, d); check("ctrl_reset", d, CTRL_RESET);
        rd_reg(COUNT_OFS, d); check("count_reset", d, COUNT_RESET);
        wr_reg(CTRL_OFS, 16'hFFFF);
        rd_reg(CTRL_OFS, d); check("ctrl_mask", d, CTRL_WMASK);
        wr_reg(CTRL_OFS, 16'h0000);
        step();
        rd_reg(COUNT_OFS, d);
        wr_reg(COUNT_OFS, 16'h1234);
        wr_reg(4'hE, 16'hFFFF);
        rd_reg(COUNT_OFS, d);
        check("count_ro", d, COUNT_RESET);
        check("count_out", cnt, COUNT_RESET);
        rd_reg(CTRL_OFS, d);
        check("unmapped_wr", d, CTRL_RESET);
        rd_reg(4'hE, d); check("unmapped", d, 16'h0000);
        // each prescale code: spacing of ticks, then freeze on stop
        for (int ps = 0; ps < 4; ps++) begin
            wr_reg(CTRL_OFS, 16'h8000 | 16'(ps << 4));
            t0 = ticks; k = 0;
            while (ticks < t0 + 2 && k < 1000) begin step(); k++; end
            c1 = cyc;
            while (ticks < t0 + 3 && k < 1000) begin step(); k++; end
            check("tick_spacing", 16'(cyc - c1), 16'(div_of(ps)));
            wr_reg(CTRL_OFS, 16'h0000);
            step(); d = cnt;
            repeat (20) step();
            check("frozen_count", cnt, d);
        end
        // idle with halt bit set holds, without it runs on
        idle <= 1'b1;
        wr_reg(CTRL_OFS, 16'hA000); step(); t0 = ticks;
        repeat (20) step(); check("idle_halt", 16'(ticks - t0), 16'h0);
        wr_reg(CTRL_OFS, 16'h8000); step(); t0 = ticks;
        repeat (20) step();
        check("idle_run", 16'(ticks - t0), 16'h0014);
        idle <= 1'b0;
        // gated accumulation on the internal clock, random gate
        wr_reg(CTRL_OFS, 16'h8040); step(); t0 = ticks; n = 0;
        for (int i = 0; i < 40; i++) begin
            gate <= 1'($urandom);
            step();
            n += (gate === 1'b1);
        end
        gate <= 1'b0;
        settle_ticks("gated", n);
        // external pin with gate enabled but low: gate ignored
        for (int s = 0; s < 2; s++) begin
            wr_reg(CTRL_OFS, 16'h8042 | 16'(s << 2) | 16'(s << 4));
            step(); t0 = ticks;
            n = (s == 0) ? 1 + ($urandom % 10) : 16;
            num <= 8'(n);
            start <= 1'b1;
            step();
            start <= 1'b0;
            step();
            k = 0;
            while (busy === 1'b1 && k < 200) begin step(); k++; end
            settle_ticks("ext_pin", n / div_of(s));
        end
        // reset in mid-run clears count, tick and control at once
        reset_n <= 1'b0;
        step();
        check("reset_count", cnt, COUNT_RESET);
        check("reset_tick", 16'(tick), 16'h0000);
        reset_n <= 1'b1;
        step();
        rd_reg(CTRL_OFS, d);
        check("reset_ctrl", d, CTRL_RESET);
        check("reset_hold", cnt, COUNT_RESET);
        tally_and_finish();
    end
endmodule : testbench
